// ===== hdl/e3_frame_alignment_fsm.sv
`timescale 1ns/1ps

// Behaviour
// - hunt bitwise for alignment word, then verify
// - verify word one frame later, enter frame
// - failed verification returns to bitwise search
// - four consecutive bad frames enter out-of-frame
// - out-of-frame hunts while keeping old sync
// - in-frame to out-of-frame sets status bit 3
// - out-of-frame entry drives out-of-frame pin high
// - refind within limit returns in-frame, bit 3
// - exceeding limit moves to loss-of-frame
// - limit select bit: 24 or 8 frames
// - loss-of-frame drops sync, goes to search
// - loss-of-frame entry sets status bit 2
// - loss-of-frame entry drives loss pin high
// - acquisition sets status bits 2 and 3
// - in-frame entry drives both pins low
// - in-frame entry clears both status flags
// - count each alignment error, 16 bits
// - counter bytes clear on read, reset zero
// - start in search for F6 then 28
// - reframe bit write forces bitwise search
module e3_frame_alignment_fsm
  import e3_frame_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rx_line_clk,
  input  wire logic        rx_line_data,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             out_of_frame_indicator,
  output logic             loss_of_frame_indicator,
  output logic             frame_start,
  output logic             frame_sync_valid
);

  function automatic logic reg_hit(input logic [9:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx);
  endfunction

  frame_state_e         state;
  frame_state_e         next_state;
  logic                 clk_s1;
  logic                 clk_s2;
  logic                 clk_s3;
  logic                 data_s1;
  logic                 data_s2;
  logic                 bit_stb;
  logic [15:0]          shift;
  logic [15:0]          next_shift;
  logic                 word_ok;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic                 boundary;
  logic                 restart;
  logic [2:0]           bad_cnt;
  logic [4:0]           oof_cnt;
  logic [4:0]           oof_limit;
  logic                 oof_limit_sel;
  logic [15:0]          err_count;
  logic [15:0]          next_err_count;
  logic                 oof_int;
  logic                 lof_int;
  logic                 ev_acquire;
  logic                 ev_reacquire;
  logic                 ev_oof;
  logic                 ev_lof;
  logic                 ev_err;
  logic                 ev_reframe;
  logic                 req;
  logic                 take;
  logic                 rd_take;
  logic                 wr_take;
  logic [31:0]          rd_value;

  // link clock and data both pass two flops before any use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_s3  <= 1'b0;
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
    end
    else
    begin
      clk_s1  <= rx_line_clk;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      data_s1 <= rx_line_data;
      data_s2 <= data_s1;
    end
  end

  // data and clock share latency, so data_s2 is sampled at the edge
  assign bit_stb    = clk_s2 & ~clk_s3;
  assign next_shift = {shift[14:0], data_s2};
  assign word_ok    = (next_shift == ALIGN_WORD);
  assign boundary   = bit_stb & (bit_cnt == FRAME_LAST_BIT);
  assign oof_limit  = oof_limit_sel ? OOF_LIMIT_SHORT
                                    : OOF_LIMIT_LONG;

  always_ff @(posedge clk)
  begin
    if (rst)
      shift <= 16'h0000;
    else if (bit_stb)
      shift <= next_shift;
  end

  // bus handshake: one wait cycle, then completion
  assign req     = read | write;
  assign take    = req & ~waitrequest;
  // reads clear where readdata is captured, so no event slips between
  assign rd_take = read & waitrequest;
  assign wr_take = take & write;
  assign ev_reframe = wr_take & reg_hit(address, IDX_IO_CONTROL)
                    & byteenable[BYTE_LANE_LOW]
                    & writedata[BIT_REFRAME];

  always_comb
  begin
    next_state   = state;
    restart      = 1'b0;
    ev_acquire   = 1'b0;
    ev_reacquire = 1'b0;
    ev_oof       = 1'b0;
    ev_lof       = 1'b0;
    ev_err       = 1'b0;
    case (state)
      ST_SEARCH:
      begin
        if (bit_stb && word_ok)
        begin
          next_state = ST_VERIFY;
          restart    = 1'b1;
        end
      end
      ST_VERIFY:
      begin
        // no hunting here; only the word one frame on counts
        if (boundary)
        begin
          if (word_ok)
          begin
            next_state = ST_IN_FRAME;
            ev_acquire = 1'b1;
          end
          else
            next_state = ST_SEARCH;
        end
      end
      ST_IN_FRAME:
      begin
        if (boundary && !word_ok)
        begin
          ev_err = 1'b1;
          if (bad_cnt == BAD_FRAME_LIMIT - 3'h1)
          begin
            next_state = ST_OOF;
            ev_oof     = 1'b1;
          end
        end
      end
      ST_OOF:
      begin
        // hunt every bit; frame counter keeps the old sync meanwhile
        if (bit_stb && word_ok)
        begin
          next_state   = ST_IN_FRAME;
          ev_reacquire = 1'b1;
          restart      = 1'b1;
        end
        else if (boundary)
        begin
          ev_err = 1'b1;
          if (oof_cnt == oof_limit - 5'h01)
          begin
            next_state = ST_SEARCH;
            ev_lof     = 1'b1;
          end
        end
      end
      default:
        next_state = ST_SEARCH;
    endcase
    if (ev_reframe)
    begin
      next_state   = ST_SEARCH;
      restart      = 1'b0;
      ev_acquire   = 1'b0;
      ev_reacquire = 1'b0;
      ev_oof       = 1'b0;
      ev_lof       = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= ST_SEARCH;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bit_cnt <= BIT_CNT_ZERO;
    else if (restart)
      bit_cnt <= BIT_CNT_ZERO;
    else if (bit_stb)
      bit_cnt <= (bit_cnt == FRAME_LAST_BIT) ? BIT_CNT_ZERO
                                             : bit_cnt + 13'h0001;
  end

  // consecutive bad frames while in frame
  always_ff @(posedge clk)
  begin
    if (rst)
      bad_cnt <= 3'h0;
    else if (state != ST_IN_FRAME || next_state != ST_IN_FRAME)
      bad_cnt <= 3'h0;
    else if (boundary)
      bad_cnt <= word_ok ? 3'h0 : bad_cnt + 3'h1;
  end

  // frame periods spent out of frame
  always_ff @(posedge clk)
  begin
    if (rst)
      oof_cnt <= 5'h00;
    else if (state != ST_OOF)
      oof_cnt <= 5'h00;
    else if (boundary)
      oof_cnt <= oof_cnt + 5'h01;
  end

  // pins and status flags are the same flops, so they cannot disagree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_of_frame_indicator  <= RST_INDICATOR;
      loss_of_frame_indicator <= RST_INDICATOR;
    end
    else if (ev_reframe || ev_lof)
    begin
      out_of_frame_indicator  <= 1'b1;
      loss_of_frame_indicator <= 1'b1;
    end
    else if (ev_oof)
      out_of_frame_indicator  <= 1'b1;
    else if (ev_acquire || ev_reacquire)
    begin
      out_of_frame_indicator  <= 1'b0;
      loss_of_frame_indicator <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_start      <= 1'b0;
      frame_sync_valid <= 1'b0;
    end
    else
    begin
      frame_start      <= boundary &&
                          (next_state == ST_IN_FRAME ||
                           next_state == ST_OOF);
      frame_sync_valid <= (next_state == ST_IN_FRAME) ||
                          (next_state == ST_OOF);
    end
  end

  // interrupt status: read clears, a same-cycle event still lands
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oof_int <= 1'b0;
      lof_int <= 1'b0;
    end
    else
    begin
      if (ev_oof || ev_reacquire || ev_acquire || ev_reframe)
        oof_int <= 1'b1;
      else if (rd_take && reg_hit(address, IDX_RX_INT_STATUS))
        oof_int <= 1'b0;
      if (ev_lof || ev_acquire || ev_reframe)
        lof_int <= 1'b1;
      else if (rd_take && reg_hit(address, IDX_RX_INT_STATUS))
        lof_int <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      oof_limit_sel <= RST_LIMIT_SEL;
    else if (wr_take && reg_hit(address, IDX_RX_CONFIG_STAT) &&
             byteenable[BYTE_LANE_LOW])
      oof_limit_sel <= writedata[BIT_OOF_LIMIT_SEL];
  end

  // each byte clears on its own read; an error in that cycle survives
  always_comb
  begin
    next_err_count = err_count;
    if (rd_take && reg_hit(address, IDX_FRM_ERR_HIGH))
      next_err_count[15:8] = BYTE_ZERO;
    if (rd_take && reg_hit(address, IDX_FRM_ERR_LOW))
      next_err_count[7:0] = BYTE_ZERO;
    if (ev_err)
      next_err_count = next_err_count + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      err_count <= RST_ERR_COUNT;
    else
      err_count <= next_err_count;
  end

  always_comb
  begin
    rd_value = WORD_ZERO;
    if (reg_hit(address, IDX_RX_CONFIG_STAT))
    begin
      rd_value[BIT_OOF_LIMIT_SEL] = oof_limit_sel;
      rd_value[BIT_LOF_FLAG]      = loss_of_frame_indicator;
      rd_value[BIT_OOF_FLAG]      = out_of_frame_indicator;
    end
    else if (reg_hit(address, IDX_RX_INT_STATUS))
    begin
      rd_value[BIT_OOF_INT] = oof_int;
      rd_value[BIT_LOF_INT] = lof_int;
    end
    else if (reg_hit(address, IDX_FRM_ERR_HIGH))
      rd_value[7:0] = err_count[15:8];
    else if (reg_hit(address, IDX_FRM_ERR_LOW))
      rd_value[7:0] = err_count[7:0];
  end

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata    <= WORD_ZERO;
    end
    else
    begin
      waitrequest <= ~(req & waitrequest);
      if (rd_take)
        readdata <= rd_value;
    end
  end

endmodule

// ===== hdl/e3_frame_pkg.sv
package e3_frame_pkg;

  // alignment word, first octet in the high byte
  localparam logic [7:0]  ALIGN_OCTET_FIRST  = 8'hF6;
  localparam logic [7:0]  ALIGN_OCTET_SECOND = 8'h28;
  localparam logic [15:0] ALIGN_WORD = {ALIGN_OCTET_FIRST, ALIGN_OCTET_SECOND};

  // frame geometry in link bits
  localparam int          FRAME_BYTES    = 537;
  localparam int          BITS_PER_BYTE  = 8;
  localparam int          BIT_CNT_W      = 13;
  localparam logic [BIT_CNT_W-1:0] FRAME_LAST_BIT =
    BIT_CNT_W'(FRAME_BYTES * BITS_PER_BYTE - 1);
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 13'h0000;

  // frame-period limits
  localparam logic [2:0] BAD_FRAME_LIMIT = 3'h4;
  localparam logic [4:0] OOF_LIMIT_LONG  = 5'h18;
  localparam logic [4:0] OOF_LIMIT_SHORT = 5'h08;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IO_CONTROL      = 8'h01;
  localparam logic [7:0] IDX_RX_CONFIG_STAT  = 8'h11;
  localparam logic [7:0] IDX_RX_INT_STATUS   = 8'h14;
  localparam logic [7:0] IDX_FRM_ERR_HIGH    = 8'h52;
  localparam logic [7:0] IDX_FRM_ERR_LOW     = 8'h53;

  // field positions
  localparam int BIT_REFRAME         = 0;
  localparam int BIT_OOF_LIMIT_SEL   = 7;
  localparam int BIT_LOF_FLAG        = 6;
  localparam int BIT_OOF_FLAG        = 5;
  localparam int BIT_OOF_INT         = 3;
  localparam int BIT_LOF_INT         = 2;
  localparam int BYTE_LANE_LOW       = 0;

  // reset values
  localparam logic       RST_INDICATOR     = 1'b1;
  localparam logic       RST_LIMIT_SEL     = 1'b0;
  localparam logic [15:0] RST_ERR_COUNT    = 16'h0000;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;
  localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    ST_SEARCH   = 2'b00,
    ST_VERIFY   = 2'b01,
    ST_IN_FRAME = 2'b10,
    ST_OOF      = 2'b11
  } frame_state_e;

endpackage

// ===== testbench/e3_frame_alignment_fsm_properties.sv
`timescale 1ns/1ps
module e3_frame_alignment_fsm_properties
  import e3_frame_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        out_of_frame_indicator,
  input wire logic        loss_of_frame_indicator,
  input wire logic        frame_start,
  input wire logic        frame_sync_valid
);
  logic out_of_frame;
  logic loss_of_frame;
  logic sync;
  assign out_of_frame = out_of_frame_indicator;
  assign loss_of_frame = loss_of_frame_indicator;
  assign sync = frame_sync_valid;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // table: loss without out-of-frame is invalid
  chk_lof_needs_oof: assert property (loss_of_frame |-> out_of_frame)
    else $error("loss pin high, out-of-frame pin low");
  chk_sync_in_frame: assert property (!out_of_frame |-> sync)
    else $error("in frame without sync");
  chk_lof_no_sync: assert property (loss_of_frame |-> !sync)
    else $error("sync kept in loss of frame");
  chk_pins_fall: assert property ($fell(loss_of_frame) |-> $fell(out_of_frame))
    else $error("pins did not fall together");
  chk_oof_keeps_sync: assert property ($rose(out_of_frame) && !loss_of_frame |-> sync)
    else $error("sync lost on out-of-frame entry");
  chk_start_pulse: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  chk_start_synced: assert property (frame_start |-> sync)
    else $error("frame start without sync");
  chk_reframe_hunt: assert property (write && !waitrequest &&
    address[9:2] == IDX_IO_CONTROL && writedata[0]
    |-> ##[1:4] (out_of_frame && loss_of_frame && !sync))
    else $error("reframe did not force search");
  chk_wait_one: assert property ((read || write) && waitrequest
    |=> !waitrequest)
    else $error("bus answer late");
endmodule

bind e3_frame_alignment_fsm e3_frame_alignment_fsm_properties chk_i (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .out_of_frame_indicator(out_of_frame_indicator),
  .loss_of_frame_indicator(loss_of_frame_indicator),
  .frame_start(frame_start), .frame_sync_valid(frame_sync_valid));

// ===== testbench/e3_frame_alignment_fsm_tb.sv
`timescale 1ns/1ps
module e3_frame_alignment_fsm_tb
  import e3_frame_pkg::*;
;
  localparam int FRAME_CLKS = 53700;
  logic        clk;
  logic        rst;
  logic        lclk;
  logic        ldata;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        out_of_frame;
  logic        loss_of_frame;
  logic        sync;
  logic        run;
  logic [3:0]  be;
  logic [7:0]  rd;
  logic [7:0]  v;
  int          frames;
  int          errors;
  int          checked;

  always #5 clk = ~clk;

  e3_frame_alignment_fsm e3_frame_alignment_fsm_i (.clk(clk), .rst(rst),
    .rx_line_clk(lclk), .rx_line_data(ldata), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .out_of_frame_indicator(out_of_frame), .loss_of_frame_indicator(loss_of_frame),
    .frame_start(), .frame_sync_valid(sync));

  e3_line_source e3_line_source_i (.run(run), .bad_mask(16'hE4F4),
    .line_clk(lclk), .line_data(ldata), .frames_done(frames));

  function automatic logic [7:0] int_exp(input logic o, input logic l);
    return (8'(o) << BIT_OOF_INT) | (8'(l) << BIT_LOF_INT);
  endfunction

  task automatic final_report();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string s, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, d);
    logic w;
    int   n;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= {idx, 2'h0};
    writedata <= {24'h0, d};
    w = 1'b1;
    for (n = 0; n < 20 && w; n++)
    begin
      // read before this edge's updates: what the edge itself sampled
      @(posedge clk);
      w = waitrequest;
      rd = readdata[7:0];
    end
    read <= 1'b0;
    write <= 1'b0;
    if (w !== 1'b0)
    begin
      errors++;
      final_report();
    end
  endtask

  task automatic rchk(input string s, input logic [7:0] idx, m, e);
    bus(1'b0, idx, 8'h00);
    check(s, e, rd & m);
  endtask

  task automatic wait_sig(input logic pin, input int nf);
    int n;
    for (n = 0; n < 10 * FRAME_CLKS; n++)
    begin
      @(negedge clk);
      if ((nf < 0 && out_of_frame === pin) || (nf >= 0 && frames >= nf))
        return;
    end
    errors++;
    final_report();
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    run = 1'b0;
    read = 1'b0;
    write = 1'b0;
    be = 4'hF;
    address = 10'h000;
    writedata = 32'h0;
    errors = 0;
    checked = 0;
    v = 8'($urandom(94));
    v = 8'($urandom());
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check("oof pin", 8'h01, 8'(out_of_frame));
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'hE0, 8'h60);
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, 8'h00);
    rchk("err high", IDX_FRM_ERR_HIGH, 8'hFF, 8'h00);
    rchk("err low", IDX_FRM_ERR_LOW, 8'hFF, 8'h00);
    bus(1'b1, 8'h30, v);
    rchk("unmapped", 8'h30, 8'hFF, 8'h00);
    // random limit select; the flags must ignore writes
    bus(1'b1, IDX_RX_CONFIG_STAT, ~v);
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'hE0, {~v[7], 7'h60});
    bus(1'b1, IDX_RX_CONFIG_STAT, 8'h80);
    // lane 0 disabled: the write must leave the limit select alone
    be <= 4'hE;
    bus(1'b1, IDX_RX_CONFIG_STAT, 8'h00);
    be <= 4'hF;
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'h80, 8'h80);
    run <= 1'b1;
    wait_sig(1'b0, -1);
    check("frame", 8'h01, 8'(frames));
    check("lof pin", 8'h00, 8'(loss_of_frame));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b1));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, 8'h00);
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'h60, 8'h00);
    wait_sig(1'b0, 4);
    check("oof pin", 8'h00, 8'(out_of_frame));
    rchk("err low", IDX_FRM_ERR_LOW, 8'hFF, 8'h01);
    rchk("err low", IDX_FRM_ERR_LOW, 8'hFF, 8'h00);
    wait_sig(1'b1, -1);
    check("frame", 8'h07, 8'(frames));
    check("lof pin", 8'h00, 8'(loss_of_frame));
    check("sync", 8'h01, 8'(sync));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b0));
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'hE0, 8'hA0);
    rchk("err low", IDX_FRM_ERR_LOW, 8'hFF, 8'h04);
    rchk("err high", IDX_FRM_ERR_HIGH, 8'hFF, 8'h00);
    wait_sig(1'b0, -1);
    check("frame", 8'h08, 8'(frames));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b0));
    bus(1'b1, IDX_IO_CONTROL, 8'h01);
    wait_sig(1'b1, -1);
    check("lof pin", 8'h01, 8'(loss_of_frame));
    check("sync", 8'h00, 8'(sync));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b1));
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'hE0, 8'hE0);
    // frame 10 fails verification, so frame 12 is the one taken
    wait_sig(1'b0, -1);
    check("frame", 8'h0C, 8'(frames));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b1));
    wait_sig(1'b1, -1);
    check("frame", 8'h10, 8'(frames));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b1, 1'b0));
    // short limit: still out of frame after seven bad periods
    wait_sig(1'b0, 24);
    check("lof pin", 8'h00, 8'(loss_of_frame));
    wait_sig(1'b0, 25);
    check("lof pin", 8'h01, 8'(loss_of_frame));
    check("oof pin", 8'h01, 8'(out_of_frame));
    check("sync", 8'h00, 8'(sync));
    rchk("int", IDX_RX_INT_STATUS, 8'hFF, int_exp(1'b0, 1'b1));
    rchk("cfg", IDX_RX_CONFIG_STAT, 8'hE0, 8'hE0);
    rchk("err low", IDX_FRM_ERR_LOW, 8'hFF, 8'h0C);
    rchk("err high", IDX_FRM_ERR_HIGH, 8'hFF, 8'h00);
    final_report();
  end
endmodule

// ===== testbench/e3_line_source.sv
`timescale 1ns/1ps
module e3_line_source
  import e3_frame_pkg::*;
(
  input  wire logic        run,
  input  wire logic [15:0] bad_mask,
  output logic             line_clk,
  output logic             line_data,
  output int               frames_done
);
  logic [15:0] word;
  int          b;
  initial
  begin
    line_clk = 1'b0;
    line_data = 1'b0;
    frames_done = 0;
    wait (run);
    #3;
    forever
    begin
      // corrupt word has no run of four ones: no shifted match
      // every frame from the sixteenth on carries the corrupt word
      word = (frames_done >= 16 || bad_mask[frames_done]) ? ~ALIGN_WORD
                                                           : ALIGN_WORD;
      for (b = 0; b < FRAME_BYTES * BITS_PER_BYTE; b++)
      begin
        // payload: every third bit zero, so it never mimics the word
        line_data = (b < 16) ? word[15-b]
                             : (b % 3 != 0) && $urandom_range(1);
        #62.5 line_clk = 1'b1;
        #62.5 line_clk = 1'b0;
      end
      frames_done++;
    end
  end
endmodule
